// ### hw/run_command_source_select.sv
// Command source selector and run/stop/direction interpreter.
// Assumes keypad keys and terminals are raw pins; serial, fieldbus and PLC
// commands come from logic on mclk.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps

//
// Contract
// - Source selector takes 0..5: keypad, two terminal schemes, serial, fieldbus, PLC.
// - Source 0 takes run and stop only from the keypad.
// - Keypad forward key runs forward, reverse key runs reverse, stop key stops.
// - Eleven terminals each carry function 0..51; 1 is forward, 2 is reverse.
// - Source 1 runs forward on forward alone, reverse on reverse alone.
// - Source 1 treats both active or both inactive as stop.
// - Source 2: forward terminal is run/stop, reverse terminal picks direction.
// - Terminal run starts after run-on delay, 0.00..100.00 s, default 1.00 s.
// - Source 3 takes run commands from the upper controller over serial.
// - Station identifier 1..250, default 1; only matching traffic is obeyed.
// - Serial defaults Modbus RTU, 9600 bps, 8N1; baud 1200..38400.
module run_command_source_select #(
    parameter int DELAY_TICK_CYCLES = cmd_src_pkg::DELAY_TICK_CYC
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    input  wire cmd_src_pkg::reg_req_t    reg_req,
    output logic [31:0]                   reg_rdata,
    input  wire logic                     key_fwd,
    input  wire logic                     key_rev,
    input  wire logic                     key_stop,
    input  wire logic [10:0]              multi_function_input,
    input  wire cmd_src_pkg::serial_cmd_t serial_cmd,
    input  wire cmd_src_pkg::drive_cmd_t  fieldbus_cmd,
    input  wire cmd_src_pkg::drive_cmd_t  plc_cmd,
    output cmd_src_pkg::drive_cmd_t       drive_cmd,
    output cmd_src_pkg::serial_cfg_t      serial_cfg
);
    import cmd_src_pkg::*;

    localparam logic [PRESCALE_W-1:0] TICK_LAST = PRESCALE_W'(DELAY_TICK_CYCLES - 1);

    typedef struct packed {
        logic [2:0]                command_source_select;
        logic [13:0]               run_on_delay;
        logic [7:0]                serial_station_id;
        logic [1:0]                serial_protocol_select;
        logic [2:0]                serial_baud_select;
        logic [1:0]                serial_frame_format;
        logic [NUM_TERMS-1:0][5:0] terminal_function_define;
        logic [31:0]               rdata;
        logic [2:0]                keys_prev;
        logic                      key_run;
        logic                      key_reverse;
        logic                      ser_run;
        logic                      ser_reverse;
        logic [PRESCALE_W-1:0]     prescale;
        logic [TICKS_W-1:0]        ticks;
        logic                      term_go;
        logic                      run;
        logic                      reverse;
    } state_t;

    state_t state;
    state_t next_state;

    logic [2:0]           keys_sync;
    logic [NUM_TERMS-1:0] term_sync;
    logic [2:0]           key_rise;
    logic                 fwd_term;
    logic                 rev_term;
    logic                 term_req;
    logic                 defs_ok;
    logic [3:0]           term_index;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    sync_two_flop #(.W(3)) key_sync (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .async_in ({key_stop, key_rev, key_fwd}),
        .sync_out (keys_sync)
    );

    sync_two_flop #(.W(NUM_TERMS)) term_sync_inst (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .async_in (multi_function_input),
        .sync_out (term_sync)
    );

    assign key_rise   = keys_sync & ~state.keys_prev;
    assign term_index = reg_req.addr[5:2] - ADDR_TERM0[5:2];

    // ************************************************************
    // Terminal decode
    // ************************************************************
    always_comb begin
        fwd_term = 1'b0;
        rev_term = 1'b0;
        defs_ok  = 1'b1;
        for (int i = 0; i < NUM_TERMS; i++) begin
            fwd_term = fwd_term | (term_sync[i] && state.terminal_function_define[i] == FUNC_FWD);
            rev_term = rev_term | (term_sync[i] && state.terminal_function_define[i] == FUNC_REV);
            defs_ok  = defs_ok & (state.terminal_function_define[i] <= FUNC_MAX);
        end
        unique case (state.command_source_select)
            SRC_TWO_WIRE: term_req = fwd_term ^ rev_term;
            SRC_RUN_DIR:  term_req = fwd_term;
            default:      term_req = 1'b0;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_state           = state;
        next_state.keys_prev = keys_sync;
        next_state.rdata     = 32'h0000_0000;

        // Out-of-range writes are dropped so the live setting stays legal
        if (reg_req.wr) begin
            if (reg_req.addr == ADDR_SOURCE && reg_req.wdata[31:0] <= 32'(SOURCE_MAX)) begin
                next_state.command_source_select = reg_req.wdata[2:0];
            end
            if (reg_req.addr == ADDR_DELAY && reg_req.wdata <= 32'(DELAY_MAX)) begin
                next_state.run_on_delay = reg_req.wdata[13:0];
            end
            if (reg_req.addr == ADDR_STATION && reg_req.wdata >= 32'(STATION_MIN)
                && reg_req.wdata <= 32'(STATION_MAX)) begin
                next_state.serial_station_id = reg_req.wdata[7:0];
            end
            if (reg_req.addr == ADDR_PROTOCOL && reg_req.wdata <= 32'(PROTO_MAX)) begin
                next_state.serial_protocol_select = reg_req.wdata[1:0];
            end
            if (reg_req.addr == ADDR_BAUD && reg_req.wdata <= 32'(BAUD_MAX)) begin
                next_state.serial_baud_select = reg_req.wdata[2:0];
            end
            if (reg_req.addr == ADDR_FRAME && reg_req.wdata <= 32'(FRAME_MAX)) begin
                next_state.serial_frame_format = reg_req.wdata[1:0];
            end
            if (reg_req.addr >= ADDR_TERM0 && reg_req.addr < ADDR_STATUS
                && reg_req.addr[1:0] == 2'h0 && reg_req.wdata <= 32'(FUNC_MAX)) begin
                next_state.terminal_function_define[term_index] = reg_req.wdata[5:0];
            end
        end

        if (reg_req.rd) begin
            if (reg_req.addr >= ADDR_TERM0 && reg_req.addr < ADDR_STATUS
                && reg_req.addr[1:0] == 2'h0) begin
                next_state.rdata = {26'h0, state.terminal_function_define[term_index]};
            end else begin
                unique case (reg_req.addr)
                    ADDR_SOURCE:   next_state.rdata = {29'h0, state.command_source_select};
                    ADDR_DELAY:    next_state.rdata = {18'h0, state.run_on_delay};
                    ADDR_STATION:  next_state.rdata = {24'h0, state.serial_station_id};
                    ADDR_PROTOCOL: next_state.rdata = {30'h0, state.serial_protocol_select};
                    ADDR_BAUD:     next_state.rdata = {29'h0, state.serial_baud_select};
                    ADDR_FRAME:    next_state.rdata = {30'h0, state.serial_frame_format};
                    ADDR_STATUS:   next_state.rdata = {27'h0, state.term_go, fwd_term,
                                                       rev_term, state.run, state.reverse};
                    default:       next_state.rdata = 32'h0000_0000;
                endcase
            end
        end

        // keypad latch lives only in keypad mode
        if (state.command_source_select != SRC_KEYPAD || key_rise[2]) begin
            next_state.key_run = 1'b0;
        end else if (key_rise[0]) begin
            next_state.key_run     = 1'b1;
            next_state.key_reverse = 1'b0;
        end else if (key_rise[1]) begin
            next_state.key_run     = 1'b1;
            next_state.key_reverse = 1'b1;
        end

        if (state.command_source_select != SRC_SERIAL) begin
            next_state.ser_run = 1'b0;
        end else if (serial_cmd.valid && serial_cmd.station == state.serial_station_id) begin
            if (serial_cmd.stop) begin
                next_state.ser_run = 1'b0;
            end else if (serial_cmd.run) begin
                next_state.ser_run     = 1'b1;
                next_state.ser_reverse = serial_cmd.reverse;
            end
        end

        // run-on delay counts 10 ms steps; dropping the request restarts it
        if (!term_req) begin
            next_state.term_go  = 1'b0;
            next_state.ticks    = '0;
            next_state.prescale = '0;
        end else if (!state.term_go) begin
            if (state.ticks >= state.run_on_delay) begin
                next_state.term_go = 1'b1;
            end else if (state.prescale == TICK_LAST) begin
                next_state.prescale = '0;
                next_state.ticks    = state.ticks + 14'h0001;
            end else begin
                next_state.prescale = state.prescale + 21'h00_0001;
            end
        end

        // one active source drives the output
        // run/dir mode direction from reverse terminal
        unique case (state.command_source_select)
            SRC_KEYPAD: begin
                next_state.run     = state.key_run;
                next_state.reverse = state.key_reverse;
            end
            SRC_TWO_WIRE, SRC_RUN_DIR: begin
                next_state.run     = state.term_go & term_req;
                next_state.reverse = rev_term;
            end
            SRC_SERIAL: begin
                next_state.run     = state.ser_run;
                next_state.reverse = state.ser_reverse;
            end
            SRC_FIELDBUS: begin
                next_state.run     = fieldbus_cmd.run;
                next_state.reverse = fieldbus_cmd.reverse;
            end
            SRC_PLC: begin
                next_state.run     = plc_cmd.run;
                next_state.reverse = plc_cmd.reverse;
            end
            default: begin
                next_state.run     = 1'b0;
                next_state.reverse = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state                          <= '0;
            state.command_source_select    <= SOURCE_RESET;
            state.run_on_delay             <= DELAY_RESET;
            state.serial_station_id        <= STATION_RESET;
            state.serial_protocol_select   <= PROTO_RESET;
            state.serial_baud_select       <= BAUD_RESET;
            state.serial_frame_format      <= FRAME_RESET;
            state.terminal_function_define <= {{(NUM_TERMS-2){FUNC_NONE}}, FUNC_REV, FUNC_FWD};
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata             = state.rdata;
    assign drive_cmd.run         = state.run;
    assign drive_cmd.reverse     = state.reverse;
    assign serial_cfg.station_id = state.serial_station_id;
    assign serial_cfg.protocol   = state.serial_protocol_select;
    assign serial_cfg.baud       = state.serial_baud_select;
    assign serial_cfg.frame      = state.serial_frame_format;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    source_range_a: assert property (
        state.command_source_select <= SOURCE_MAX)
        else $error("Command source outside 0..5");

    keypad_only_a: assert property (
        state.command_source_select != SRC_KEYPAD |=> !state.key_run)
        else $error("Keypad latch active outside keypad mode");

    keypad_fwd_a: assert property (
        state.command_source_select == SRC_KEYPAD && key_rise == 3'h1 |-> ##2
        (state.command_source_select != SRC_KEYPAD || (state.run && !state.reverse)))
        else $error("Forward key did not run forward");

    keypad_stop_a: assert property (
        state.command_source_select == SRC_KEYPAD && key_rise[2] |=> !state.key_run ##1
        (state.command_source_select != SRC_KEYPAD || !state.run))
        else $error("Stop key did not stop");

    term_define_a: assert property (
        defs_ok)
        else $error("Terminal function code above 51");

    two_wire_fwd_a: assert property (
        state.command_source_select == SRC_TWO_WIRE && state.term_go && fwd_term && !rev_term
        |=> (state.command_source_select != SRC_TWO_WIRE || (state.run && !state.reverse)))
        else $error("Two-wire forward not obeyed");

    two_wire_stop_a: assert property (
        state.command_source_select == SRC_TWO_WIRE && fwd_term == rev_term |-> ##2
        (state.command_source_select != SRC_TWO_WIRE || !state.run))
        else $error("Two-wire both/neither did not stop");

    run_dir_a: assert property (
        state.run && state.command_source_select == SRC_RUN_DIR
        && $past(state.command_source_select) == SRC_RUN_DIR |-> state.reverse == $past(rev_term))
        else $error("Direction terminal not followed");

    delay_done_a: assert property (
        $rose(state.term_go) |-> $past(state.ticks) >= $past(state.run_on_delay))
        else $error("Run started before run-on delay");

    delay_zero_a: assert property (
        term_req && !state.term_go && state.run_on_delay == 14'h0000 |=> state.term_go)
        else $error("Zero delay did not start at once");

    station_match_a: assert property (
        serial_cmd.valid && serial_cmd.station != state.serial_station_id
        && state.command_source_select == SRC_SERIAL && $stable(state.command_source_select)
        |=> $stable(state.ser_run))
        else $error("Foreign station command obeyed");

    serial_cfg_a: assert property (
        state.serial_baud_select <= BAUD_MAX && state.serial_frame_format <= FRAME_MAX
        && state.serial_station_id >= STATION_MIN && state.serial_station_id <= STATION_MAX)
        else $error("Serial setting out of range");

    dir_only_a: assert property (
        state.command_source_select == SRC_RUN_DIR && !fwd_term |-> ##2
        (state.command_source_select != SRC_RUN_DIR || !state.run))
        else $error("Direction input alone started drive");

    keypad_run_c:  cover property (state.command_source_select == SRC_KEYPAD && $rose(state.run));
    two_wire_c:    cover property (state.command_source_select == SRC_TWO_WIRE && $rose(state.run));
    run_dir_rev_c: cover property (state.command_source_select == SRC_RUN_DIR
                                   && state.run && state.reverse);
    serial_run_c:  cover property (state.command_source_select == SRC_SERIAL && $rose(state.run));

endmodule

// ### hw/cmd_src_pkg.sv
// Constants, register map and carrier types for the command source selector.
// Assumes a 200 MHz mclk and a plain one-cycle register port.
package cmd_src_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 5;
    localparam int DELAY_TICK_NS   = 10_000_000;  // One run-on delay step, 0.01 s
    localparam int DELAY_TICK_CYC  = DELAY_TICK_NS / CLK_PERIOD_NS;
    localparam int PRESCALE_W      = 21;
    localparam int TICKS_W         = 14;

    // ************************************************************
    // Register map, byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_SOURCE   = 8'h00;
    localparam logic [7:0] ADDR_DELAY    = 8'h04;
    localparam logic [7:0] ADDR_STATION  = 8'h08;
    localparam logic [7:0] ADDR_PROTOCOL = 8'h0C;
    localparam logic [7:0] ADDR_BAUD     = 8'h10;
    localparam logic [7:0] ADDR_FRAME    = 8'h14;
    localparam logic [7:0] ADDR_TERM0    = 8'h18;
    localparam logic [7:0] ADDR_STATUS   = 8'h44;

    // ************************************************************
    // Field limits and reset values
    // ************************************************************
    localparam int          NUM_TERMS     = 11;
    localparam logic [2:0]  SOURCE_MAX    = 3'h5;
    localparam logic [2:0]  SOURCE_RESET  = 3'h1;
    localparam logic [13:0] DELAY_MAX     = 14'h2710;  // 100.00 s
    localparam logic [13:0] DELAY_RESET   = 14'h0064;  // 1.00 s
    localparam logic [7:0]  STATION_MIN   = 8'h01;
    localparam logic [7:0]  STATION_MAX   = 8'hFA;
    localparam logic [7:0]  STATION_RESET = 8'h01;
    localparam logic [1:0]  PROTO_MAX     = 2'h2;
    localparam logic [1:0]  PROTO_RESET   = 2'h0;      // Modbus RTU
    localparam logic [2:0]  BAUD_MAX      = 3'h5;      // 38400 bps
    localparam logic [2:0]  BAUD_RESET    = 3'h3;      // 9600 bps
    localparam logic [1:0]  FRAME_MAX     = 2'h3;
    localparam logic [1:0]  FRAME_RESET   = 2'h0;      // 8 data, no parity, 1 stop
    localparam logic [5:0]  FUNC_MAX      = 6'h33;
    localparam logic [5:0]  FUNC_FWD      = 6'h01;
    localparam logic [5:0]  FUNC_REV      = 6'h02;
    localparam logic [5:0]  FUNC_NONE     = 6'h00;

    // ************************************************************
    // Command source encodings
    // ************************************************************
    localparam logic [2:0] SRC_KEYPAD   = 3'h0;
    localparam logic [2:0] SRC_TWO_WIRE = 3'h1;
    localparam logic [2:0] SRC_RUN_DIR  = 3'h2;
    localparam logic [2:0] SRC_SERIAL   = 3'h3;
    localparam logic [2:0] SRC_FIELDBUS = 3'h4;
    localparam logic [2:0] SRC_PLC      = 3'h5;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] station;
        logic       run;
        logic       stop;
        logic       reverse;
    } serial_cmd_t;

    typedef struct packed {
        logic run;
        logic reverse;
    } drive_cmd_t;

    typedef struct packed {
        logic [7:0] station_id;
        logic [1:0] protocol;
        logic [2:0] baud;
        logic [1:0] frame;
    } serial_cfg_t;

endpackage

// ### hw/sync_two_flop.sv
// Two-flop synchroniser for a bundle of independent pin levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/100ps
module sync_two_flop #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb begin
        next_state.first  = async_in;
        next_state.second = state.first;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.second;

endmodule

// ### testbench/operator_side_model.sv
// Operator side model: keypad keys, terminal pins and upper-level serial controller.
// Assumes the bench calls its tasks; every pin changes just after a rising mclk edge.
`timescale 1ns/100ps
module operator_side_model (
    input  wire logic          mclk,
    output logic [2:0]         keys,
    output logic [10:0]        terms,
    output cmd_src_pkg::serial_cmd_t ser
);
    import cmd_src_pkg::*;

    initial begin
        keys  = 3'h0;
        terms = 11'h000;
        ser   = '0;
    end

    // Key press held long enough to pass the synchroniser
    task automatic press(input int k);
        @(posedge mclk);
        keys[k] <= 1'b1;
        repeat (4) @(posedge mclk);
        keys[k] <= 1'b0;
    endtask

    task automatic set_terms(input logic [10:0] v);
        @(posedge mclk);
        terms <= v;
    endtask

    // Controller frame, decoded 8N1 at the agreed rate
    task automatic send(input logic [7:0] st, input logic run, input logic stp,
                        input logic rev);
        @(posedge mclk);
        ser <= '{valid: 1'b1, station: st, run: run, stop: stp, reverse: rev};
        @(posedge mclk);
        // Fields outside the pulse are scrambled so nothing leans on stale values
        ser <= '{valid: 1'b0, station: ~st, run: ~run, stop: ~stp, reverse: ~rev};
    endtask
endmodule

// ### testbench/run_command_source_select_tb.sv
// Self-checking bench for the command source selector.
// Assumes the operator side model drives keys, terminals and serial commands.
`timescale 1ns/100ps
module run_command_source_select_tb;
    import cmd_src_pkg::*;
    // Short delay step keeps run-on delays to a few cycles
    localparam int TICK = 4;
    logic        mclk;
    logic        rst_b;
    reg_req_t    req;
    logic [31:0] rdata;
    logic [2:0]  keys;
    logic [10:0] terms;
    serial_cmd_t ser;
    drive_cmd_t  fb;
    drive_cmd_t  plc;
    drive_cmd_t  drv;
    serial_cfg_t cfg;
    int          miscompares;
    int          n_compared;

    always #2.5 mclk = ~mclk;

    operator_side_model i_pan (.mclk(mclk), .keys(keys), .terms(terms), .ser(ser));

    run_command_source_select #(.DELAY_TICK_CYCLES(TICK)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata),
        .key_fwd(keys[0]), .key_rev(keys[1]), .key_stop(keys[2]),
        .multi_function_input(terms), .serial_cmd(ser), .fieldbus_cmd(fb),
        .plc_cmd(plc), .drive_cmd(drv), .serial_cfg(cfg));

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Fieldbus and PLC commands change just after an edge
    task automatic set_ext(input drive_cmd_t f, input drive_cmd_t p);
        @(posedge mclk);
        fb  <= f;
        plc <= p;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("BAD %0t value %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 chk_word(rdata, exp);
    endtask

    // Direction is only judged while the drive runs
    task automatic chk_drv(input logic run, input logic rev);
        #1;
        n_compared++;
        if (drv.run !== run || (run && drv.reverse !== rev)) begin
            $display("BAD %0t drive %b expected %b%b", $time, drv, run, rev);
            miscompares++;
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #50_000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        req = '0;
        fb = '0;
        plc = '0;
        miscompares = 0;
        n_compared = 0;
        wt(6);
        rst_b <= 1'b1;
        chk_reg(ADDR_SOURCE, 32'h1);
        chk_reg(ADDR_DELAY, 32'h64);
        chk_reg(ADDR_STATION, 32'h1);
        chk_reg(ADDR_PROTOCOL, 32'h0);
        chk_reg(ADDR_BAUD, 32'h3);
        chk_reg(ADDR_FRAME, 32'h0);
        chk_reg(ADDR_TERM0, 32'h1);
        chk_reg(ADDR_TERM0 + 8'h04, 32'h2);
        chk_reg(8'h48, 32'h0);
        chk_word({17'h0, cfg}, 32'h8C);
        $display("reset values done");
        wr(ADDR_SOURCE, 32'h6);
        chk_reg(ADDR_SOURCE, 32'h1);
        wr(ADDR_STATION, 32'h0);
        wr(ADDR_STATION, 32'hFB);
        chk_reg(ADDR_STATION, 32'h1);
        wr(ADDR_STATION, 32'hFA);
        wr(ADDR_TERM0 + 8'h08, 32'h34);
        chk_reg(ADDR_TERM0 + 8'h08, 32'h0);
        wr(ADDR_TERM0 + 8'h08, 32'h33);
        chk_reg(ADDR_TERM0 + 8'h08, 32'h33);
        wr(ADDR_BAUD, 32'h5);
        wr(ADDR_BAUD, 32'h6);
        wr(ADDR_PROTOCOL, 32'h3);
        wr(ADDR_FRAME, 32'h3);
        wt(1);
        chk_word({17'h0, cfg}, 32'h7D17);
        $display("range limits done");
        wr(ADDR_DELAY, 32'h2);
        i_pan.set_terms(11'h001);
        wt(6);
        chk_drv(1'b0, 1'b0);
        wt(14);
        chk_drv(1'b1, 1'b0);
        i_pan.set_terms(11'h003);
        wt(8);
        chk_drv(1'b0, 1'b0);
        i_pan.set_terms(11'h002);
        wt(20);
        chk_drv(1'b1, 1'b1);
        i_pan.set_terms(11'h000);
        wt(8);
        chk_drv(1'b0, 1'b0);
        $display("two wire mode done");
        wr(ADDR_DELAY, 32'h0);
        wr(ADDR_SOURCE, 32'h2);
        i_pan.set_terms(11'h002);
        wt(8);
        chk_drv(1'b0, 1'b0);
        i_pan.set_terms(11'h003);
        wt(8);
        chk_drv(1'b1, 1'b1);
        chk_reg(ADDR_STATUS, 32'h1F);
        i_pan.set_terms(11'h001);
        wt(6);
        chk_drv(1'b1, 1'b0);
        wr(ADDR_TERM0, 32'h0);
        wt(4);
        chk_drv(1'b0, 1'b0);
        wr(ADDR_TERM0 + 8'h14, 32'h1);
        i_pan.set_terms(11'h020);
        wt(8);
        chk_drv(1'b1, 1'b0);
        $display("run and direction mode done");
        wr(ADDR_SOURCE, 32'h0);
        wt(8);
        chk_drv(1'b0, 1'b0);
        i_pan.press(0);
        wt(4);
        chk_drv(1'b1, 1'b0);
        i_pan.press(1);
        wt(4);
        chk_drv(1'b1, 1'b1);
        i_pan.press(2);
        wt(4);
        chk_drv(1'b0, 1'b0);
        i_pan.set_terms(11'h000);
        set_ext(2'h3, 2'h3);
        wt(4);
        chk_drv(1'b0, 1'b0);
        $display("keypad done");
        wr(ADDR_SOURCE, 32'h3);
        i_pan.send(8'h01, 1'b1, 1'b0, 1'b0);
        wt(4);
        chk_drv(1'b0, 1'b0);
        i_pan.send(8'hFA, 1'b1, 1'b0, 1'b1);
        wt(4);
        chk_drv(1'b1, 1'b1);
        i_pan.send(8'hFA, 1'b0, 1'b1, 1'b0);
        wt(4);
        chk_drv(1'b0, 1'b0);
        $display("serial done");
        wr(ADDR_SOURCE, 32'h4);
        wt(4);
        chk_drv(1'b1, 1'b1);
        set_ext(2'h2, 2'h1);
        wt(2);
        chk_drv(1'b1, 1'b0);
        set_ext(2'h0, 2'h2);
        wt(2);
        chk_drv(1'b0, 1'b0);
        wr(ADDR_SOURCE, 32'h5);
        wt(4);
        chk_drv(1'b1, 1'b0);
        set_ext(2'h1, 2'h3);
        wt(2);
        chk_drv(1'b1, 1'b1);
        $display("fieldbus and plc done");
        wt(1);
        rst_b <= 1'b0;
        wt(2);
        chk_drv(1'b0, 1'b0);
        rst_b <= 1'b1;
        chk_reg(ADDR_SOURCE, 32'h1);
        chk_reg(ADDR_TERM0 + 8'h14, 32'h0);
        chk_reg(ADDR_STATION, 32'h1);
        $display("mid-run reset done");
        report_and_stop();
    end
endmodule
